// ### agu_defs.svh
// register offsets, field positions, reset values and step counts of the address generator
//----------------------------------------------------------------------
// Function
// R1: circular correction may apply to any working register used as pointer.
// R2: incrementing checks above upper bound, decrementing below lower bound; overshoot wraps.
// R3: corrected pointer written back only for pre/post modify; offset mode keeps pointer.
// R4: bit-reversed generation exists only on the X write path.
// R5: only the modifier is bit-reversed; pointer keeps normal bit order.
// R6: bit-reverse needs pointer select not 15, enable set, pre/post increment.
// R7: software aligns a 2^N byte bit-reversed buffer to 2^N bytes.
// R8: a 15-bit modifier field gives the bit-reverse pivot point.
// R9: bit-reversed addresses assume words; LSB zero, modifier scaled to bytes.
// R10: bit-reverse only for pre/post increment word writes; else ordinary address.
// R11: bit-reverse next address is pointer plus reversed modifier; normal step ignored.
// R12: bit-reverse beats circular on write path; read path keeps circular correction.
// R13: software avoids reading via bit-reverse pointer right after a control write.
// R14: without any correction the ordinary mode arithmetic result passes unchanged.
//----------------------------------------------------------------------
`ifndef AGU_DEFS_SVH
`define AGU_DEFS_SVH

`define AGU_ADDR_W        12
`define AGU_OFS_CIRC      12'h000
`define AGU_OFS_MSTART    12'h004
`define AGU_OFS_MEND      12'h008
`define AGU_OFS_BREV      12'h00C
`define AGU_OFS_STAT      12'h010

`define AGU_CIRC_EN_BIT   15
`define AGU_CIRC_MSEL_LSB 0
`define AGU_CIRC_BSEL_LSB 4
`define AGU_BREV_EN_BIT   15
`define AGU_BREV_MOD_MSB  14

`define AGU_CIRC_RST      16'h00FF
`define AGU_MADDR_RST     16'h0000
`define AGU_BREV_RST      16'h0000

`define AGU_SP_IDX        4'hF
`define AGU_STEP_BYTE     16'h0001
`define AGU_STEP_WORD     16'h0002

`endif

// ### agu_pkg.sv
// types shared by the address generator files
package agu_pkg;

  typedef enum logic [2:0] {
    AM_DIRECT,
    AM_POST_INC,
    AM_POST_DEC,
    AM_PRE_INC,
    AM_PRE_DEC,
    AM_OFFSET
  } agu_mode_t;

  typedef struct packed {
    logic [3:0]  ptr_idx;
    logic [15:0] ptr;
    agu_mode_t   mode;
    logic [15:0] ofs;
    logic        byte_acc;
  } agu_req_t;

  typedef struct packed {
    logic [15:0] ea;
    logic        wb_en;
    logic [15:0] wb_val;
  } agu_rsp_t;

  typedef struct packed {
    logic     wrap;
    agu_rsp_t rsp;
  } agu_calc_t;

endpackage

// ### agu_bitrev.sv
// reverse-carry word adder for bit-reversed pointer stepping
`timescale 1ns/1ps
module agu_bitrev #(
  parameter int W = 15
) (
  input  wire logic [W:0]   ptr,
  input  wire logic [W-1:0] modifier,
  output logic      [W:0]   nxt
);
  logic [W-1:0] rev_p;
  logic [W-1:0] rev_m;
  logic [W-1:0] sum;

  // carries run toward the low bits: reverse, add, reverse back
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_rev
      assign rev_p[i]   = ptr[W-i];        // R5
      assign rev_m[i]   = modifier[W-1-i]; // R5
      assign nxt[W-i]   = sum[i];          // R11
    end
  endgenerate

  assign sum    = rev_p + rev_m;   // R11
  assign nxt[0] = 1'b0;            // R9
endmodule // agu_bitrev

// ### agu_core.sv
// effective address generator with circular and bit-reversed correction, APB registers
`timescale 1ns/1ps
`include "agu_defs.svh"
module agu_core (
  input  wire logic                    ref_clk,
  input  wire logic                    sys_rst,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`AGU_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    rd_valid,
  input  wire agu_pkg::agu_req_t       rd_req,
  output logic                         rd_vld,
  output agu_pkg::agu_rsp_t            rd_rsp,
  input  wire logic                    wr_valid,
  input  wire agu_pkg::agu_req_t       wr_req,
  output logic                         wr_vld,
  output agu_pkg::agu_rsp_t            wr_rsp
);
  import agu_pkg::*;

  //----------------------------------------------------------------------
  // registers
  //----------------------------------------------------------------------
  logic [15:0] circ_r;
  logic [15:0] mstart_r;
  logic [15:0] mend_r;
  logic [15:0] brev_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic        rd_vld_r;
  logic        wr_vld_r;
  agu_rsp_t    rd_rsp_r;
  agu_rsp_t    wr_rsp_r;
  logic        rd_wrap_r;
  logic        wr_wrap_r;
  logic        wr_brev_r;

  //----------------------------------------------------------------------
  // apb decode
  //----------------------------------------------------------------------
  wire         setup_ph = psel & ~penable;
  wire         wr_acc   = psel & penable & pwrite;
  wire         hit_circ = (paddr == `AGU_OFS_CIRC);
  wire         hit_mst  = (paddr == `AGU_OFS_MSTART);
  wire         hit_mend = (paddr == `AGU_OFS_MEND);
  wire         hit_brev = (paddr == `AGU_OFS_BREV);
  wire         hit_stat = (paddr == `AGU_OFS_STAT);
  wire         hit_any  = hit_circ | hit_mst | hit_mend | hit_brev | hit_stat;
  // status is read only, so a write to it is refused like an unmapped one
  wire         bad_acc  = ~hit_any | (hit_stat & pwrite);
  wire [15:0]  stat_val = {13'h0000, rd_wrap_r, wr_wrap_r, wr_brev_r};
  wire [15:0]  rd_sel   = hit_circ ? circ_r   :
                          hit_mst  ? mstart_r :
                          hit_mend ? mend_r   :
                          hit_brev ? brev_r   :
                          hit_stat ? stat_val : 16'h0000;

  assign pready  = 1'b1;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      prdata_r  <= pwrite ? 32'h00000000 : {16'h0000, rd_sel};
      pslverr_r <= bad_acc;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      circ_r   <= `AGU_CIRC_RST;
      mstart_r <= `AGU_MADDR_RST;
      mend_r   <= `AGU_MADDR_RST;
      brev_r   <= `AGU_BREV_RST;
    end else if (wr_acc) begin
      if (hit_circ) circ_r   <= pwdata[15:0];
      if (hit_mst)  mstart_r <= pwdata[15:0];
      if (hit_mend) mend_r   <= pwdata[15:0];
      if (hit_brev) brev_r   <= pwdata[15:0];
    end
  end

  //----------------------------------------------------------------------
  // control fields
  //----------------------------------------------------------------------
  wire         circ_en   = circ_r[`AGU_CIRC_EN_BIT];
  wire [3:0]   circ_sel  = circ_r[`AGU_CIRC_MSEL_LSB +: 4];
  wire [3:0]   brev_sel  = circ_r[`AGU_CIRC_BSEL_LSB +: 4];
  wire         brev_en   = brev_r[`AGU_BREV_EN_BIT];
  wire [14:0]  brev_mod  = brev_r[`AGU_BREV_MOD_MSB:0];  // R8

  //----------------------------------------------------------------------
  // ordinary arithmetic with circular correction
  //----------------------------------------------------------------------
  function automatic agu_calc_t calc_ea(agu_req_t q, logic circ,
                                        logic [15:0] lo, logic [15:0] hi);
    logic [15:0] step;
    logic [15:0] nv;
    logic [15:0] len;
    logic [15:0] cv;
    logic        inc;
    logic        wrap;
    agu_calc_t   r;
    step = q.byte_acc ? `AGU_STEP_BYTE : `AGU_STEP_WORD;
    inc  = (q.mode == AM_POST_INC) || (q.mode == AM_PRE_INC) ||
           ((q.mode == AM_OFFSET) && !q.ofs[15]);
    case (q.mode)
      AM_POST_INC, AM_PRE_INC: nv = q.ptr + step;
      AM_POST_DEC, AM_PRE_DEC: nv = q.ptr - step;
      AM_OFFSET:               nv = q.ptr + q.ofs;
      default:                 nv = q.ptr;
    endcase
    len  = hi - lo + 16'h0001;
    // compare by magnitude, not equality, so a large step still wraps
    wrap = circ && (q.mode != AM_DIRECT) && (inc ? (nv > hi) : (nv < lo)); // R2
    cv   = wrap ? (inc ? nv - len : nv + len) : nv; // R2 R14
    r.wrap = wrap;
    case (q.mode)
      AM_POST_INC, AM_POST_DEC: begin
        r.rsp.ea     = q.ptr;
        r.rsp.wb_en  = 1'b1;    // R3
        r.rsp.wb_val = cv;
      end
      AM_PRE_INC, AM_PRE_DEC: begin
        r.rsp.ea     = cv;
        r.rsp.wb_en  = 1'b1;    // R3
        r.rsp.wb_val = cv;
      end
      AM_OFFSET: begin
        r.rsp.ea     = cv;
        r.rsp.wb_en  = 1'b0;    // R3
        r.rsp.wb_val = q.ptr;
      end
      default: begin
        r.rsp.ea     = q.ptr;   // R14
        r.rsp.wb_en  = 1'b0;
        r.rsp.wb_val = q.ptr;
      end
    endcase
    return r;
  endfunction

  //----------------------------------------------------------------------
  // read path: circular only
  //----------------------------------------------------------------------
  wire         rd_circ = circ_en && (rd_req.ptr_idx == circ_sel); // R1 R12
  agu_calc_t   rd_calc;
  assign rd_calc = calc_ea(rd_req, rd_circ, mstart_r, mend_r);

  //----------------------------------------------------------------------
  // write path: bit-reverse first, circular otherwise
  //----------------------------------------------------------------------
  wire         wr_incm  = (wr_req.mode == AM_POST_INC) || (wr_req.mode == AM_PRE_INC);
  wire         wr_brev  = brev_en && (brev_sel != `AGU_SP_IDX) &&
                          (wr_req.ptr_idx == brev_sel) &&
                          wr_incm && !wr_req.byte_acc;            // R4 R6 R10
  wire         wr_circ  = circ_en && (wr_req.ptr_idx == circ_sel) && !wr_brev; // R1 R12
  wire [15:0]  brev_nxt;
  agu_calc_t   wr_norm;
  agu_rsp_t    wr_sel;

  agu_bitrev #(
    .W (15)
  ) u_bitrev (
    .ptr      (wr_req.ptr),
    .modifier (brev_mod),
    .nxt      (brev_nxt)
  );

  assign wr_norm = calc_ea(wr_req, wr_circ, mstart_r, mend_r);
  // the ordinary step is dropped; the pointer low bit is forced clear
  assign wr_sel.ea     = wr_brev ? ((wr_req.mode == AM_PRE_INC) ? brev_nxt :
                                    {wr_req.ptr[15:1], 1'b0})
                                 : wr_norm.rsp.ea;                // R9 R11
  assign wr_sel.wb_en  = wr_brev ? 1'b1 : wr_norm.rsp.wb_en;
  assign wr_sel.wb_val = wr_brev ? brev_nxt : wr_norm.rsp.wb_val;  // R11

  //----------------------------------------------------------------------
  // result registers
  //----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_vld_r  <= 1'b0;
      rd_rsp_r  <= '0;
      rd_wrap_r <= 1'b0;
    end else begin
      rd_vld_r <= rd_valid;
      if (rd_valid) begin
        rd_rsp_r  <= rd_calc.rsp;
        rd_wrap_r <= rd_calc.wrap;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_vld_r  <= 1'b0;
      wr_rsp_r  <= '0;
      wr_wrap_r <= 1'b0;
      wr_brev_r <= 1'b0;
    end else begin
      wr_vld_r <= wr_valid;
      if (wr_valid) begin
        wr_rsp_r  <= wr_sel;
        wr_wrap_r <= wr_norm.wrap;
        wr_brev_r <= wr_brev;
      end
    end
  end

  assign rd_vld = rd_vld_r;
  assign rd_rsp = rd_rsp_r;
  assign wr_vld = wr_vld_r;
  assign wr_rsp = wr_rsp_r;

  //----------------------------------------------------------------------
  // checks
  //----------------------------------------------------------------------
  AST_WRAP_NEEDS_SEL: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(rd_wrap_r) |-> $past(rd_valid && circ_en && rd_req.ptr_idx == circ_sel)) // R1
    else $error("read wrap without circular selection");

  AST_INC_WRAP_BOUND: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rd_valid && rd_circ && rd_req.mode == AM_POST_INC && mstart_r <= mend_r &&
     rd_req.ptr >= mstart_r && rd_req.ptr <= mend_r) ##1 rd_wrap_r
    |-> rd_rsp.wb_val <= mend_r && rd_rsp.wb_val >= mstart_r) // R2
    else $error("incrementing wrap left the buffer");

  AST_OFS_NO_WB: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rd_valid && rd_req.mode == AM_OFFSET |=> rd_vld && !rd_rsp.wb_en) // R3
    else $error("offset mode wrote the pointer back");

  AST_BREV_COND: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_valid ##1 wr_brev_r |-> $past(brev_en && brev_sel != `AGU_SP_IDX &&
      wr_req.ptr_idx == brev_sel && !wr_req.byte_acc && wr_incm)) // R4 R6 R10
    else $error("bit-reverse used outside its conditions");

  AST_BREV_LSB: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_vld && wr_brev_r |-> !wr_rsp.ea[0] && !wr_rsp.wb_val[0] && wr_rsp.wb_en) // R9 R11
    else $error("bit-reversed address has low bit set");

  AST_BREV_ZERO_MOD: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_valid && wr_brev && brev_mod == 15'h0000
    |=> wr_rsp.wb_val == {$past(wr_req.ptr[15:1]), 1'b0}) // R5 R8
    else $error("zero modifier moved the pointer");

  AST_BREV_PRIO: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_vld && wr_brev_r |-> !wr_wrap_r) // R12
    else $error("circular correction acted with bit-reverse");

  AST_PLAIN_STEP: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rd_valid && !rd_circ && rd_req.mode == AM_POST_INC && !rd_req.byte_acc
    |=> rd_rsp.wb_val == $past(rd_req.ptr) + 16'h0002 &&
        rd_rsp.ea == $past(rd_req.ptr)) // R14
    else $error("plain post-increment result wrong");

  COV_BREV_WRITE: cover property (@(posedge ref_clk) disable iff (sys_rst)
    wr_vld && wr_brev_r);
  COV_READ_WRAP: cover property (@(posedge ref_clk) disable iff (sys_rst)
    rd_vld && rd_wrap_r);
  COV_WRITE_WRAP: cover property (@(posedge ref_clk) disable iff (sys_rst)
    wr_vld && wr_wrap_r);
  COV_OFS_WRAP: cover property (@(posedge ref_clk) disable iff (sys_rst)
    rd_valid && rd_req.mode == AM_OFFSET && rd_calc.wrap);

endmodule // agu_core

// ### agu_tb.sv
// self-checking bench for the address generator: apb registers, circular and bit-reversed paths
`timescale 1ns/1ps
`include "agu_defs.svh"
module tb;
  import agu_pkg::*;
  logic        ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        rd_valid, rd_vld, wr_valid, wr_vld;
  agu_req_t    rd_req, wr_req;
  agu_rsp_t    rd_rsp, wr_rsp;
  int          fail_count, comparisons, cycles;

  agu_core DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rd_valid(rd_valid), .rd_req(rd_req), .rd_vld(rd_vld),
    .rd_rsp(rd_rsp), .wr_valid(wr_valid), .wr_req(wr_req), .wr_vld(wr_vld),
    .wr_rsp(wr_rsp));

  always #2 ref_clk = ~ref_clk;

  // the run needs about 130 cycles; the ceiling leaves ample margin
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      complete_run();
    end
  end

  //----------------------------------------------------------------------
  // shared tasks
  //----------------------------------------------------------------------
  task automatic complete_run();
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // no fixed wait is assumed; only the bench timeout ends a stuck transfer
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d, input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    chk("pslverr_wr", {31'h0, xe}, {31'h0, e});
  endtask

  task automatic reg_rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk("prdata", x, q);
    chk("pslverr_rd", {31'h0, xe}, {31'h0, e});
  endtask

  // one request on either path, answer judged one cycle later
  task automatic xfer(input logic wr, input logic [3:0] idx, input logic [15:0] p,
                      input agu_mode_t m, input logic [15:0] o, input logic b,
                      input logic [15:0] ea, input logic we, input logic [15:0] wv);
    agu_req_t r;
    agu_rsp_t s;
    logic     v;
    r = '{ptr_idx: idx, ptr: p, mode: m, ofs: o, byte_acc: b};
    @(posedge ref_clk);
    if (wr) begin
      wr_req <= r;
      wr_valid <= 1'b1;
    end else begin
      rd_req <= r;
      rd_valid <= 1'b1;
    end
    @(posedge ref_clk);
    wr_valid <= 1'b0;
    rd_valid <= 1'b0;
    #1;
    v = wr ? wr_vld : rd_vld;
    s = wr ? wr_rsp : rd_rsp;
    chk("vld", 32'h1, {31'h0, v});
    chk("ea", {16'h0, ea}, {16'h0, s.ea});
    chk("wb_en", {31'h0, we}, {31'h0, s.wb_en});
    chk("wb_val", {16'h0, wv}, {16'h0, s.wb_val});
  endtask

  //----------------------------------------------------------------------
  // scenarios
  //----------------------------------------------------------------------
  task automatic t_regs();
    reg_rd(`AGU_OFS_CIRC, 32'h0000_00FF, 1'b0);
    reg_rd(`AGU_OFS_MEND, 32'h0000_0000, 1'b0);
    reg_rd(`AGU_OFS_BREV, 32'h0000_0000, 1'b0);
    reg_wr(`AGU_OFS_BREV, 32'hFFFF_8008, 1'b0);
    reg_rd(`AGU_OFS_BREV, 32'h0000_8008, 1'b0);
    reg_wr(`AGU_OFS_BREV, 32'h0000_0000, 1'b0);
    reg_rd(12'h014, 32'h0000_0000, 1'b1);
    reg_wr(`AGU_OFS_STAT, 32'h0000_0007, 1'b1);
  endtask

  task automatic t_plain();
    xfer(1'b0, 4'h1, 16'h1000, AM_POST_INC, 16'h0, 1'b0, 16'h1000, 1'b1, 16'h1002);
    xfer(1'b0, 4'h1, 16'h1000, AM_PRE_DEC, 16'h0, 1'b1, 16'h0FFF, 1'b1, 16'h0FFF);
    xfer(1'b1, 4'h2, 16'h1000, AM_PRE_INC, 16'h0, 1'b1, 16'h1001, 1'b1, 16'h1001);
    xfer(1'b1, 4'h2, 16'h1000, AM_OFFSET, 16'h0010, 1'b0, 16'h1010, 1'b0, 16'h1000);
    xfer(1'b0, 4'h3, 16'h1234, AM_DIRECT, 16'h0, 1'b0, 16'h1234, 1'b0, 16'h1234);
  endtask

  task automatic t_circ();
    reg_wr(`AGU_OFS_MSTART, 32'h0000_1000, 1'b0);
    reg_wr(`AGU_OFS_MEND, 32'h0000_101F, 1'b0);
    reg_wr(`AGU_OFS_CIRC, 32'h0000_8003, 1'b0);
    xfer(1'b0, 4'h3, 16'h101E, AM_POST_INC, 16'h0, 1'b0, 16'h101E, 1'b1, 16'h1000);
    xfer(1'b0, 4'h3, 16'h1018, AM_OFFSET, 16'h000C, 1'b0, 16'h1004, 1'b0, 16'h1018);
    xfer(1'b1, 4'h3, 16'h1000, AM_PRE_DEC, 16'h0, 1'b0, 16'h101E, 1'b1, 16'h101E);
    xfer(1'b0, 4'h3, 16'h1000, AM_POST_DEC, 16'h0, 1'b0, 16'h1000, 1'b1, 16'h101E);
    xfer(1'b0, 4'h3, 16'h1002, AM_OFFSET, 16'hFFF8, 1'b0, 16'h101A, 1'b0, 16'h1002);
    xfer(1'b0, 4'h2, 16'h101E, AM_POST_INC, 16'h0, 1'b0, 16'h101E, 1'b1, 16'h1020);
    reg_wr(`AGU_OFS_CIRC, 32'h0000_800A, 1'b0);
    xfer(1'b1, 4'hA, 16'h101F, AM_PRE_INC, 16'h0, 1'b1, 16'h1000, 1'b1, 16'h1000);
  endtask

  // sixteen-word buffer placed at 0x1000, low five address bits zero
  task automatic t_brev();
    reg_wr(`AGU_OFS_CIRC, 32'h0000_0025, 1'b0);
    reg_wr(`AGU_OFS_BREV, 32'h0000_8008, 1'b0);
    // no read through the pointer follows the control write directly
    xfer(1'b1, 4'h2, 16'h1000, AM_POST_INC, 16'h0, 1'b0, 16'h1000, 1'b1, 16'h1010);
    reg_rd(`AGU_OFS_STAT, 32'h0000_0001, 1'b0);
    xfer(1'b1, 4'h2, 16'h1010, AM_POST_INC, 16'h0040, 1'b0, 16'h1010, 1'b1, 16'h1008);
    xfer(1'b1, 4'h2, 16'h1008, AM_PRE_INC, 16'h0, 1'b0, 16'h1018, 1'b1, 16'h1018);
    xfer(1'b1, 4'h2, 16'h1011, AM_POST_INC, 16'h0, 1'b0, 16'h1010, 1'b1, 16'h1008);
    xfer(1'b1, 4'h2, 16'h1000, AM_POST_INC, 16'h0, 1'b1, 16'h1000, 1'b1, 16'h1001);
    xfer(1'b1, 4'h2, 16'h1000, AM_PRE_DEC, 16'h0, 1'b0, 16'h0FFE, 1'b1, 16'h0FFE);
    xfer(1'b0, 4'h2, 16'h1000, AM_POST_INC, 16'h0, 1'b0, 16'h1000, 1'b1, 16'h1002);
    xfer(1'b1, 4'h3, 16'h1000, AM_POST_INC, 16'h0, 1'b0, 16'h1000, 1'b1, 16'h1002);
    reg_wr(`AGU_OFS_CIRC, 32'h0000_00F5, 1'b0);
    xfer(1'b1, 4'hF, 16'h1000, AM_POST_INC, 16'h0, 1'b0, 16'h1000, 1'b1, 16'h1002);
    reg_wr(`AGU_OFS_CIRC, 32'h0000_0025, 1'b0);
    reg_wr(`AGU_OFS_BREV, 32'h0000_0008, 1'b0);
    xfer(1'b1, 4'h2, 16'h1000, AM_POST_INC, 16'h0, 1'b0, 16'h1000, 1'b1, 16'h1002);
    // zero pivot: the pointer keeps its place
    reg_wr(`AGU_OFS_BREV, 32'h0000_8000, 1'b0);
    xfer(1'b1, 4'h2, 16'h1006, AM_POST_INC, 16'h0, 1'b0, 16'h1006, 1'b1, 16'h1006);
  endtask

  task automatic t_prio();
    reg_wr(`AGU_OFS_CIRC, 32'h0000_8022, 1'b0);
    reg_wr(`AGU_OFS_BREV, 32'h0000_8008, 1'b0);
    xfer(1'b1, 4'h2, 16'h1010, AM_POST_INC, 16'h0, 1'b0, 16'h1010, 1'b1, 16'h1008);
    xfer(1'b0, 4'h2, 16'h101E, AM_POST_INC, 16'h0, 1'b0, 16'h101E, 1'b1, 16'h1000);
    xfer(1'b1, 4'h2, 16'h101F, AM_PRE_INC, 16'h0, 1'b1, 16'h1000, 1'b1, 16'h1000);
    reg_rd(`AGU_OFS_STAT, 32'h0000_0006, 1'b0);
  endtask

  //----------------------------------------------------------------------
  // main sequence
  //----------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    sys_rst = 1'b1;
    {psel, penable, pwrite, rd_valid, wr_valid} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rd_req = '0;
    wr_req = '0;
    fail_count = 0;
    comparisons = 0;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_plain();
    t_circ();
    t_brev();
    t_prio();
    complete_run();
  end
endmodule // tb
